// *** design/pcr_regs.sv ***
/*
  Management register slice of a 10/100 PHY reached over MDIO: speed
  fallback config, receive error counter, indirect pair and the extended
  idle-power and combo control registers. Assumes mdc and mdio_i are
  sampled synchronously to clk, with mdc well below clk/4.
*/
// Behaviour
// - with the read-latch bit set a read shifts out a copy taken at its start.
// - speed fallback enable defaults on and takes effect at a software reset.
// - fallback happens after the attempt field plus two failures, applied at reset.
// - timer bypass makes any established link count as a success.
// - without bypass a link lost before 2.5 s counts as one more failure.
// - a 16-bit receive error count starts at zero, counts errors and clears on any write.
// - the error count stops at all ones instead of wrapping.
// - the data register at 0x1f reaches the extended register named at 0x1e.
// - in 10 Mbps with idle-off set the transmit DAC is off while nothing is sent.
// - the remote loopback bit turns line data back onto the line.
// - long-frame enable raises the receive frame limit from 4.5KB to 18KB.
// - in RMII the carrier pad follows receive-valid or combined carrier by a select.
// - wake detection runs only while its enable bit, default off, is set.
// - the clock-direction bit resets from a strap and marks interface clocks as inputs.
// - the reduced-pin and clock-direction pair decodes to one of four MAC modes.
// - the reduced-pin bit, default off, moves the MAC side from MII to RMII.
`timescale 1ns/100ps
`default_nettype none
module pcr_regs #(
  parameter int unsigned STABLE_CYCLES = pcr_pkg::STABLE_CYCLES,
  parameter int ERR_W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] phy_addr,
  input wire logic mdc,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic soft_reset,
  input wire logic clk_dir_strap,
  input wire logic link_up,
  input wire logic an_fail,
  input wire logic rx_error,
  input wire logic speed_10,
  input wire logic tx_pending,
  input wire logic rx_dv_int,
  input wire logic crs_dv_int,
  output logic speed_downgraded,
  output logic [3:0] fallback_retry_count,
  output logic tx_dac_on,
  output logic remote_loopback_en,
  output logic rx_long_frame_en,
  output logic [14:0] rx_frame_limit,
  output logic crs_dv_pad,
  output logic wake_detect_en,
  output logic iface_clocks_are_inputs,
  output logic reduced_pin_en,
  output pcr_pkg::pcr_mac_mode_e mac_mode
);
  generate
    if (ERR_W != 16)
    begin : g_chk
      $error("error counter must fill one 16-bit register");
    end
  endgenerate

  typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} pcr_mdio_e;

  // mdio frame state
  pcr_mdio_e md_st_r, md_st_nxt;
  logic [5:0] cnt_r, cnt_nxt;
  logic [12:0] hdr_r, hdr_nxt;
  logic [15:0] sh_r, sh_nxt;
  logic [15:0] cap_r, cap_nxt;
  logic latch_r, latch_nxt;
  logic is_rd_r, is_rd_nxt;
  logic mine_r, mine_nxt;
  logic md_o_r, md_o_nxt;
  logic md_oe_r, md_oe_nxt;
  logic mdc_q_r;
  logic mdc_rise;
  logic [4:0] regad;
  logic in_slice;
  logic [15:0] live;
  logic [15:0] src;
  logic [3:0] idx;
  logic wr_go;
  logic [15:0] wr_data;

  // register state
  logic [15:0] speed_downgrade_config_r, speed_downgrade_config_nxt;
  logic [15:0] ind_addr_r, ind_addr_nxt;
  logic [15:0] pwr_r, pwr_nxt;
  logic [15:0] combo_r, combo_nxt;
  logic strap_done_r, strap_done_nxt;
  logic [15:0] ext_val;
  logic [15:0] err_count;
  logic err_clr;

  // output state
  logic dac_on_r, dac_on_nxt;
  logic crs_pad_r, crs_pad_nxt;
  logic [14:0] limit_r, limit_nxt;

  assign mdc_rise = mdc && !mdc_q_r;
  assign regad = hdr_r[4:0];
  assign in_slice = regad == pcr_pkg::REG_SPEED_CFG || regad == pcr_pkg::REG_RX_ERR
    || regad == pcr_pkg::REG_IND_ADDR || regad == pcr_pkg::REG_IND_DATA;

  always_comb
  begin
    ext_val = 16'h0000;
    if (ind_addr_r == pcr_pkg::EXT_TENBASE_PWR)
      ext_val = pwr_r;
    else if (ind_addr_r == pcr_pkg::EXT_COMBO)
      ext_val = combo_r;
  end

  always_comb
  begin
    live = 16'h0000;
    unique case (regad)
      pcr_pkg::REG_SPEED_CFG: live = speed_downgrade_config_r & pcr_pkg::SPEED_DOWNGRADE_CONFIG_WMASK;
      pcr_pkg::REG_RX_ERR: live = err_count;
      pcr_pkg::REG_IND_ADDR: live = ind_addr_r;
      pcr_pkg::REG_IND_DATA: live = ext_val;
      default: live = 16'h0000;
    endcase
  end

  assign src = latch_r ? cap_r : live;
  assign idx = 4'(cnt_r) ^ 4'hf;
  assign wr_data = {sh_r[14:0], mdio_i};
  assign wr_go = mdc_rise && md_st_r == MD_DATA && cnt_r == pcr_pkg::DATA_LAST
    && !is_rd_r && mine_r;

  // mdio frame: preamble, header, turnaround, data
  always_comb
  begin
    md_st_nxt = md_st_r;
    cnt_nxt = cnt_r;
    hdr_nxt = hdr_r;
    sh_nxt = sh_r;
    cap_nxt = cap_r;
    latch_nxt = latch_r;
    is_rd_nxt = is_rd_r;
    mine_nxt = mine_r;
    md_o_nxt = md_o_r;
    md_oe_nxt = md_oe_r;
    if (mdc_rise)
    begin
      unique case (md_st_r)
        MD_PRE:
        begin
          if (mdio_i)
            cnt_nxt = (cnt_r == pcr_pkg::PRE_ONES) ? cnt_r : cnt_r + 6'h1;
          else
          begin
            md_st_nxt = (cnt_r == pcr_pkg::PRE_ONES) ? MD_HDR : MD_PRE;
            cnt_nxt = '0;
          end
        end
        MD_HDR:
        begin
          hdr_nxt = {hdr_r[11:0], mdio_i};
          cnt_nxt = cnt_r + 6'h1;
          if (cnt_r == pcr_pkg::HDR_LAST)
          begin
            md_st_nxt = MD_TA;
            cnt_nxt = '0;
          end
        end
        MD_TA:
        begin
          if (cnt_r == 6'h0)
          begin
            is_rd_nxt = hdr_r[11:10] == pcr_pkg::OP_READ;
            mine_nxt = hdr_r[12] && hdr_r[9:5] == phy_addr && in_slice;
            cnt_nxt = 6'h1;
            if (!hdr_r[12] || (hdr_r[11:10] != pcr_pkg::OP_READ
              && hdr_r[11:10] != pcr_pkg::OP_WRITE))
            begin
              md_st_nxt = MD_PRE;
              cnt_nxt = '0;
            end
            else if (mine_nxt && is_rd_nxt)
            begin
              cap_nxt = live;
              latch_nxt = speed_downgrade_config_r[pcr_pkg::LATCH_BIT];
              md_oe_nxt = 1'b1;
              md_o_nxt = 1'b0;
            end
          end
          else
          begin
            md_st_nxt = MD_DATA;
            cnt_nxt = '0;
            if (is_rd_r && mine_r)
              md_o_nxt = src[15];
          end
        end
        MD_DATA:
        begin
          sh_nxt = wr_data;
          if (cnt_r == pcr_pkg::DATA_LAST)
          begin
            md_st_nxt = MD_PRE;
            cnt_nxt = '0;
            md_oe_nxt = 1'b0;
            md_o_nxt = 1'b0;
          end
          else
          begin
            cnt_nxt = cnt_r + 6'h1;
            if (is_rd_r && mine_r)
              md_o_nxt = src[idx - 4'h1];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      md_st_r <= MD_PRE;
      cnt_r <= '0;
      hdr_r <= '0;
      sh_r <= '0;
      cap_r <= '0;
      latch_r <= 1'b0;
      is_rd_r <= 1'b0;
      mine_r <= 1'b0;
      md_o_r <= 1'b0;
      md_oe_r <= 1'b0;
      mdc_q_r <= 1'b1;
    end
    else
    begin
      md_st_r <= md_st_nxt;
      cnt_r <= cnt_nxt;
      hdr_r <= hdr_nxt;
      sh_r <= sh_nxt;
      cap_r <= cap_nxt;
      latch_r <= latch_nxt;
      is_rd_r <= is_rd_nxt;
      mine_r <= mine_nxt;
      md_o_r <= md_o_nxt;
      md_oe_r <= md_oe_nxt;
      mdc_q_r <= mdc;
    end
  end

  assign mdio_o = md_o_r;
  assign mdio_oe = md_oe_r;

  // register writes and strap capture
  always_comb
  begin
    speed_downgrade_config_nxt = speed_downgrade_config_r;
    ind_addr_nxt = ind_addr_r;
    pwr_nxt = pwr_r;
    combo_nxt = combo_r;
    strap_done_nxt = 1'b1;
    if (!strap_done_r)
      combo_nxt[pcr_pkg::CLKDIR_BIT] = clk_dir_strap;
    if (wr_go)
    begin
      unique case (regad)
        pcr_pkg::REG_SPEED_CFG:
          speed_downgrade_config_nxt = (wr_data & pcr_pkg::SPEED_DOWNGRADE_CONFIG_WMASK)
            | (speed_downgrade_config_r & ~pcr_pkg::SPEED_DOWNGRADE_CONFIG_WMASK);
        pcr_pkg::REG_IND_ADDR: ind_addr_nxt = wr_data;
        pcr_pkg::REG_IND_DATA:
        begin
          if (ind_addr_r == pcr_pkg::EXT_TENBASE_PWR)
            pwr_nxt = wr_data;
          else if (ind_addr_r == pcr_pkg::EXT_COMBO)
            combo_nxt = wr_data;
        end
        default:
        begin
        end
      endcase
    end
  end

  assign err_clr = wr_go && regad == pcr_pkg::REG_RX_ERR;

  // registered pin-facing outputs
  always_comb
  begin
    dac_on_nxt = !(speed_10 && pwr_r[pcr_pkg::IDLE_OFF_BIT] && !tx_pending);
    crs_pad_nxt = crs_dv_int;
    if (combo_r[pcr_pkg::RMII_BIT] && combo_r[pcr_pkg::SRC_SEL_BIT])
      crs_pad_nxt = rx_dv_int;
    limit_nxt = combo_r[pcr_pkg::LONG_BIT] ? pcr_pkg::FRAME_LONG
      : pcr_pkg::FRAME_SHORT;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      speed_downgrade_config_r <= pcr_pkg::SPEED_DOWNGRADE_CONFIG_RST;
      ind_addr_r <= pcr_pkg::IND_RST;
      pwr_r <= pcr_pkg::PWR_RST;
      combo_r <= pcr_pkg::COMBO_RST;
      strap_done_r <= 1'b0;
      dac_on_r <= 1'b1;
      crs_pad_r <= 1'b0;
      limit_r <= pcr_pkg::FRAME_SHORT;
    end
    else
    begin
      speed_downgrade_config_r <= speed_downgrade_config_nxt;
      ind_addr_r <= ind_addr_nxt;
      pwr_r <= pwr_nxt;
      combo_r <= combo_nxt;
      strap_done_r <= strap_done_nxt;
      dac_on_r <= dac_on_nxt;
      crs_pad_r <= crs_pad_nxt;
      limit_r <= limit_nxt;
    end
  end

  pcr_sat_counter #(
    .W(ERR_W)
  ) u_err_cnt (
    .clk(clk),
    .arst_n(arst_n),
    .inc(rx_error),
    .clr(err_clr),
    .count(err_count)
  );

  pcr_fallback_fsm #(
    .STABLE_CYCLES(STABLE_CYCLES),
    .TW(29)
  ) u_fallback (
    .clk(clk),
    .arst_n(arst_n),
    .soft_reset(soft_reset),
    .en_cfg(speed_downgrade_config_r[pcr_pkg::FB_EN_BIT]),
    .att_cfg(speed_downgrade_config_r[pcr_pkg::ATT_LSB +: pcr_pkg::ATT_W]),
    .bypass(speed_downgrade_config_r[pcr_pkg::BYPASS_BIT]),
    .link_up(link_up),
    .an_fail(an_fail),
    .downgraded(speed_downgraded),
    .retry_count(fallback_retry_count)
  );

  assign tx_dac_on = dac_on_r;
  assign crs_dv_pad = crs_pad_r;
  assign rx_frame_limit = limit_r;
  assign rx_long_frame_en = combo_r[pcr_pkg::LONG_BIT];
  assign remote_loopback_en = combo_r[pcr_pkg::LOOP_BIT];
  assign wake_detect_en = combo_r[pcr_pkg::WAKE_BIT];
  assign iface_clocks_are_inputs = combo_r[pcr_pkg::CLKDIR_BIT];
  assign reduced_pin_en = combo_r[pcr_pkg::RMII_BIT];
  assign mac_mode = pcr_pkg::pcr_mac_mode_e'({combo_r[pcr_pkg::RMII_BIT],
    combo_r[pcr_pkg::CLKDIR_BIT]});

  sequence s_rd_start;
    mdc_rise && md_st_r == MD_TA && cnt_r == 6'h0 && hdr_r[12]
      && hdr_r[11:10] == pcr_pkg::OP_READ && hdr_r[9:5] == phy_addr && in_slice;
  endsequence
  sequence s_turn_driven;
    md_oe_r && !md_o_r && md_st_r == MD_TA;
  endsequence

  a_read_turn: assert property (@(posedge clk) disable iff (!arst_n)
    s_rd_start |=> s_turn_driven ##0 cap_r == $past(live))
    else $error("read start did not capture and turn the line");
  a_latch_hold: assert property (@(posedge clk) disable iff (!arst_n)
    md_st_r == MD_DATA && latch_r && is_rd_r && mine_r |=> $stable(cap_r))
    else $error("latched read value changed mid frame");
  a_ext_write: assert property (@(posedge clk) disable iff (!arst_n)
    wr_go && regad == pcr_pkg::REG_IND_DATA && ind_addr_r == pcr_pkg::EXT_COMBO
    && strap_done_r |=> combo_r == $past(wr_data))
    else $error("indirect write missed the combo register");
  a_dac_idle_off: assert property (@(posedge clk) disable iff (!arst_n)
    speed_10 && pwr_r[pcr_pkg::IDLE_OFF_BIT] && !tx_pending |=> !tx_dac_on)
    else $error("idle DAC left on");
  a_crs_source: assert property (@(posedge clk) disable iff (!arst_n)
    combo_r[pcr_pkg::RMII_BIT] && combo_r[pcr_pkg::SRC_SEL_BIT]
    |=> crs_dv_pad == $past(rx_dv_int))
    else $error("carrier pad not from receive valid");
  a_frame_limit: assert property (@(posedge clk) disable iff (!arst_n)
    combo_r[pcr_pkg::LONG_BIT] |=> rx_frame_limit == pcr_pkg::FRAME_LONG)
    else $error("long frame limit not applied");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    wr_go && regad == pcr_pkg::REG_SPEED_CFG |=> speed_downgrade_config_r[15:12] == 4'h0 && !speed_downgrade_config_r[0])
    else $error("reserved bits took a write");
endmodule
`default_nettype wire

// *** shared/pcr_pkg.sv ***
/*
  Constants, field layout and types of the PHY management register slice.
  Assumes a 125 MHz core clock and clause-22 style MDIO framing.
*/
`default_nettype none
package pcr_pkg;
  // register addresses on the management bus
  localparam logic [4:0] REG_SPEED_CFG = 5'h14;
  localparam logic [4:0] REG_RX_ERR = 5'h15;
  localparam logic [4:0] REG_IND_ADDR = 5'h1e;
  localparam logic [4:0] REG_IND_DATA = 5'h1f;
  // extended space addresses
  localparam logic [15:0] EXT_TENBASE_PWR = 16'h200a;
  localparam logic [15:0] EXT_COMBO = 16'h4000;
  // reset values and writable masks
  localparam logic [15:0] SPEED_DOWNGRADE_CONFIG_RST = 16'h082c;
  localparam logic [15:0] SPEED_DOWNGRADE_CONFIG_WMASK = 16'h0ffe;
  localparam logic [15:0] PWR_RST = 16'hca02;
  localparam logic [15:0] COMBO_RST = 16'h0000;
  localparam logic [15:0] IND_RST = 16'h0000;
  // field positions
  localparam int LATCH_BIT = 11;
  localparam int FB_EN_BIT = 5;
  localparam int ATT_LSB = 2;
  localparam int ATT_W = 3;
  localparam int BYPASS_BIT = 1;
  localparam int IDLE_OFF_BIT = 10;
  localparam int LOOP_BIT = 11;
  localparam int LONG_BIT = 5;
  localparam int SRC_SEL_BIT = 4;
  localparam int WAKE_BIT = 2;
  localparam int RMII_BIT = 1;
  localparam int CLKDIR_BIT = 0;
  // speed fallback
  localparam logic FB_EN_RST = 1'b1;
  localparam logic [2:0] FB_ATT_RST = 3'h3;
  localparam logic [3:0] ATT_EXTRA = 4'h2;
  localparam int STABLE_TIME_MS = 2500;
  localparam int CLK_KHZ = 125000;
  localparam int unsigned STABLE_CYCLES = STABLE_TIME_MS * CLK_KHZ;
  // receive frame limits in bytes
  localparam logic [14:0] FRAME_LONG = 15'h4800;
  localparam logic [14:0] FRAME_SHORT = 15'h1200;
  // mdio framing
  localparam logic [5:0] PRE_ONES = 6'h20;
  localparam logic [5:0] HDR_LAST = 6'h0c;
  localparam logic [5:0] DATA_LAST = 6'h0f;
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  typedef enum logic [1:0] {
    MODE_MII = 2'b00,
    MODE_RP_VARIANT_E = 2'b01,
    MODE_RP_VARIANT_TWO = 2'b10,
    MODE_RP_VARIANT_ONE = 2'b11
  } pcr_mac_mode_e;
endpackage
`default_nettype wire

// *** design/pcr_sat_counter.sv ***
/*
  Saturating event counter with clear; a count in the clear cycle wins.
  Assumes a single-cycle increment pulse synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module pcr_sat_counter #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic inc,
  input wire logic clr,
  output logic [W-1:0] count
);
  generate
    if (W < 2)
    begin : g_chk
      $error("counter width too small");
    end
  endgenerate

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  localparam logic [W-1:0] MAX = '1;

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (clr)
      cnt_nxt = '0;
    if (inc)
    begin
      if (clr)
        cnt_nxt = W'(1);
      else if (cnt_r != MAX)
        cnt_nxt = cnt_r + W'(1);
      else
        cnt_nxt = MAX;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= '0;
    else
      cnt_r <= cnt_nxt;
  end

  assign count = cnt_r;

  a_count_incr: assert property (@(posedge clk) disable iff (!arst_n)
    inc && !clr && cnt_r != MAX |=> cnt_r == $past(cnt_r) + W'(1))
    else $error("error count did not advance");
  a_count_saturate: assert property (@(posedge clk) disable iff (!arst_n)
    cnt_r == MAX && !clr |=> cnt_r == MAX)
    else $error("error count left its ceiling");
endmodule
`default_nettype wire

// *** design/pcr_fallback_fsm.sv ***
/*
  Speed fallback tracker: counts failed negotiation attempts and flags a
  downgrade. Assumes link_up is a level and an_fail a one-cycle pulse.
*/
`timescale 1ns/100ps
`default_nettype none
module pcr_fallback_fsm #(
  parameter int unsigned STABLE_CYCLES = pcr_pkg::STABLE_CYCLES,
  parameter int TW = 29
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic soft_reset,
  input wire logic en_cfg,
  input wire logic [2:0] att_cfg,
  input wire logic bypass,
  input wire logic link_up,
  input wire logic an_fail,
  output logic downgraded,
  output logic [3:0] retry_count
);
  generate
    if (STABLE_CYCLES < 1 || TW > 31 || STABLE_CYCLES > (2 ** TW))
    begin : g_chk
      $error("stability timer does not fit");
    end
  endgenerate

  typedef enum logic [1:0] {FB_DOWN, FB_TIMING, FB_UP} pcr_fb_e;
  pcr_fb_e st_r, st_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic dg_r, dg_nxt, en_r, en_nxt;
  logic [2:0] att_r, att_nxt;
  logic fail;
  logic [3:0] lim;

  assign lim = {1'b0, att_r} + pcr_pkg::ATT_EXTRA;

  always_comb
  begin
    st_nxt = st_r;
    tmr_nxt = tmr_r;
    cnt_nxt = cnt_r;
    dg_nxt = dg_r;
    en_nxt = en_r;
    att_nxt = att_r;
    fail = 1'b0;
    unique case (st_r)
      FB_DOWN:
      begin
        if (link_up && bypass)
        begin
          st_nxt = FB_UP;
          cnt_nxt = '0;
        end
        else if (link_up)
        begin
          st_nxt = FB_TIMING;
          tmr_nxt = '0;
        end
        else
          fail = an_fail;
      end
      FB_TIMING:
      begin
        if (link_up && (bypass || tmr_r == TW'(STABLE_CYCLES - 1)))
        begin
          st_nxt = FB_UP;
          cnt_nxt = '0;
        end
        else if (!link_up)
        begin
          st_nxt = FB_DOWN;
          fail = !bypass;
        end
        else
          tmr_nxt = tmr_r + TW'(1);
      end
      FB_UP:
      begin
        if (!link_up)
          st_nxt = FB_DOWN;
      end
    endcase
    if (fail)
    begin
      if (en_r && cnt_r + 4'h1 >= lim)
      begin
        dg_nxt = 1'b1;
        cnt_nxt = '0;
      end
      else
        cnt_nxt = cnt_r + 4'h1;
    end
    if (soft_reset)
    begin
      en_nxt = en_cfg;
      att_nxt = att_cfg;
      dg_nxt = 1'b0;
      cnt_nxt = '0;
      st_nxt = FB_DOWN;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= FB_DOWN;
      tmr_r <= '0;
      cnt_r <= '0;
      dg_r <= 1'b0;
      en_r <= pcr_pkg::FB_EN_RST;
      att_r <= pcr_pkg::FB_ATT_RST;
    end
    else
    begin
      st_r <= st_nxt;
      tmr_r <= tmr_nxt;
      cnt_r <= cnt_nxt;
      dg_r <= dg_nxt;
      en_r <= en_nxt;
      att_r <= att_nxt;
    end
  end

  assign downgraded = dg_r;
  assign retry_count = cnt_r;

  a_cfg_on_reset: assert property (@(posedge clk) disable iff (!arst_n)
    soft_reset |=> en_r == $past(en_cfg) && att_r == $past(att_cfg))
    else $error("fallback config not taken at soft reset");
  a_bypass_success: assert property (@(posedge clk) disable iff (!arst_n)
    st_r == FB_DOWN && link_up && bypass && !soft_reset |=> st_r == FB_UP && cnt_r == 4'h0)
    else $error("bypassed link not taken as success");
  a_retry_incr: assert property (@(posedge clk) disable iff (!arst_n)
    st_r == FB_TIMING && !link_up && !bypass && !soft_reset && cnt_r + 4'h1 < lim
    |=> cnt_r == $past(cnt_r) + 4'h1 && st_r == FB_DOWN)
    else $error("short link not counted as failure");
  a_fallback_limit: assert property (@(posedge clk) disable iff (!arst_n)
    !dg_r ##1 dg_r |-> $past(cnt_r) + 4'h1 == $past(lim) && $past(en_r))
    else $error("downgrade at wrong attempt count");
endmodule
`default_nettype wire

// *** verification/pcr_mdio_station.sv ***
/*
  MDIO station manager model: sends clause-22 frames, reads answers.
  Assumes the shared line has a pull-up and is resolved by the bench.
*/
`timescale 1ns/100ps
`default_nettype none
module pcr_mdio_station (
  input wire logic clk,
  input wire logic line,
  output logic mdc,
  output logic m_o,
  output logic m_oe
);
  initial
  begin
    mdc = 1'b0;
    m_o = 1'b1;
    m_oe = 1'b0;
  end
  // one mdc period, 3 clk low then 3 clk high; line sampled before the rise
  task automatic bit_cyc(input logic b, input logic drv, output logic s);
    m_o <= b;
    m_oe <= drv;
    mdc <= 1'b0;
    repeat (3) @(posedge clk);
    s = line;
    mdc <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // full frame with fresh preamble; released during turnaround and data of a read
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [63:0] f;
    logic s;
    integer i;
    f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
    rd = 16'h0000;
    for (i = 63; i >= 0; i--)
    begin
      bit_cyc(f[i], !(op == 2'b10 && i < 18), s);
      if (i < 16)
        rd[i] = s;
    end
    m_oe <= 1'b0;
    m_o <= 1'b1;
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** verification/pcr_regs_tb_top.sv ***
/*
  Self-checking bench of the register slice, driven over MDIO by the
  station model. Assumes the short stability timer set below.
*/
`timescale 1ns/100ps
`default_nettype none
module pcr_regs_tb_top;
  logic clk, arst_n, mdc, mdio_i, mdio_o, mdio_oe, m_o, m_oe, soft_reset, strap;
  logic link_up, an_fail, rx_error, speed_10, tx_pending, rx_dv, crs_dv;
  logic dg, dac, lp, lng, pad, wk, ckin, rp;
  logic [3:0] retry;
  logic [14:0] lim;
  pcr_pkg::pcr_mac_mode_e mode;
  logic [15:0] rd, v;
  integer n_fail, check_count, seed, i, n;
  assign mdio_i = mdio_oe ? mdio_o : (m_oe ? m_o : 1'b1);
  pcr_regs #(.STABLE_CYCLES(20)) dut_u (.clk(clk), .arst_n(arst_n), .phy_addr(5'h03),
    .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe), .soft_reset(soft_reset),
    .clk_dir_strap(strap), .link_up(link_up), .an_fail(an_fail), .rx_error(rx_error),
    .speed_10(speed_10), .tx_pending(tx_pending), .rx_dv_int(rx_dv), .crs_dv_int(crs_dv),
    .speed_downgraded(dg), .fallback_retry_count(retry), .tx_dac_on(dac),
    .remote_loopback_en(lp), .rx_long_frame_en(lng), .rx_frame_limit(lim), .crs_dv_pad(pad),
    .wake_detect_en(wk), .iface_clocks_are_inputs(ckin), .reduced_pin_en(rp), .mac_mode(mode));
  pcr_mdio_station st_u (.clk(clk), .line(mdio_i), .mdc(mdc), .m_o(m_o), .m_oe(m_oe));
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    st_u.xfer(pcr_pkg::OP_WRITE, 5'h03, a, d, rd);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [15:0] e);
    st_u.xfer(pcr_pkg::OP_READ, 5'h03, a, 16'h0000, rd);
    chk(nm, e, rd);
  endtask
  task automatic errs(input integer k);
    rx_error <= 1'b1;
    repeat (k) @(posedge clk);
    rx_error <= 1'b0;
    @(posedge clk);
  endtask
  task automatic fails(input integer k);
    repeat (k)
    begin
      an_fail <= 1'b1;
      @(posedge clk);
      an_fail <= 1'b0;
      @(posedge clk);
    end
    @(posedge clk);
  endtask
  task automatic lnk(input integer k);
    link_up <= 1'b1;
    repeat (k) @(posedge clk);
    link_up <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic sreset;
    soft_reset <= 1'b1;
    @(posedge clk);
    soft_reset <= 1'b0;
    @(posedge clk);
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial
  begin
    repeat (95000) @(posedge clk);
    n_fail++;
    end_sim;
  end
  initial
  begin
    seed = 32'h4b74;
    n_fail = 0;
    check_count = 0;
    {arst_n, soft_reset, link_up, an_fail, rx_error, speed_10, tx_pending, rx_dv, crs_dv} = 0;
    strap = 1'b1;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("limit", 16'h1200, 16'(lim));
    rdc("speed_downgrade_config", 5'h14, 16'h082c);
    rdc("rx_error_counter", 5'h15, 16'h0000);
    rdc("ind", 5'h1e, 16'h0000);
    wr(5'h1e, 16'h200a);
    rdc("pwr", 5'h1f, 16'hca02);
    wr(5'h1e, 16'h4000);
    rdc("combo", 5'h1f, 16'h0001);
    wr(5'h14, 16'hffff);
    rdc("speed_downgrade_config_rsvd", 5'h14, 16'h0ffe);
    wr(5'h14, 16'h082c);
    n = ($random(seed) & 16'h00ff) + 1;
    errs(n);
    rdc("errcnt", 5'h15, 16'(n));
    fork
      st_u.xfer(pcr_pkg::OP_READ, 5'h03, 5'h15, 16'h0000, rd);
      begin
        repeat (340) @(posedge clk);
        errs(10);
      end
    join
    chk("latched", 16'(n), rd);
    rdc("errcnt2", 5'h15, 16'(n + 10));
    wr(5'h14, 16'h002c);
    fork
      st_u.xfer(pcr_pkg::OP_READ, 5'h03, 5'h15, 16'h0000, rd);
      begin
        repeat (281) @(posedge clk);
        errs(3);
      end
    join
    chk("live", 16'(n + 13), rd);
    wr(5'h14, 16'h082c);
    wr(5'h15, 16'h0000);
    rdc("cleared", 5'h15, 16'h0000);
    errs(65538);
    rdc("saturated", 5'h15, 16'hffff);
    for (i = 0; i < 4; i++)
    begin
      v = ($random(seed) & 16'h083c) | 16'(i);
      rx_dv <= v[3];
      crs_dv <= !v[3];
      wr(5'h1f, v);
      repeat (2) @(posedge clk);
      chk("loop", 16'(v[11]), 16'(lp));
      chk("long", 16'(v[5]), 16'(lng));
      chk("limit", v[5] ? 16'h4800 : 16'h1200, 16'(lim));
      chk("pad", 16'((v[1] & v[4]) ? v[3] : !v[3]), 16'(pad));
      chk("wake", 16'(v[2]), 16'(wk));
      chk("clkin", 16'(v[0]), 16'(ckin));
      chk("mode", 16'(v[1:0]), 16'(mode));
      chk("rmii", 16'(v[1]), 16'(rp));
      rdc("combo_rd", 5'h1f, v);
    end
    wr(5'h1e, 16'h200a);
    speed_10 <= 1'b1;
    repeat (2) @(posedge clk);
    chk("dac_keep", 16'h0001, 16'(dac));
    wr(5'h1f, 16'hce02);
    repeat (2) @(posedge clk);
    chk("dac_off", 16'h0000, 16'(dac));
    tx_pending <= 1'b1;
    repeat (2) @(posedge clk);
    chk("dac_on", 16'h0001, 16'(dac));
    fails(4);
    chk("retry4", 16'h0004, 16'(retry));
    chk("not_down", 16'h0000, 16'(dg));
    fails(1);
    chk("down", 16'h0001, 16'(dg));
    sreset();
    lnk(5);
    chk("short_link", 16'h0001, 16'(retry));
    lnk(30);
    chk("stable_link", 16'h0000, 16'(retry));
    wr(5'h14, 16'h082e);
    fails(1);
    lnk(5);
    chk("bypass", 16'h0000, 16'(retry));
    wr(5'h14, 16'h0800);
    sreset();
    fails(7);
    chk("fb_off", 16'h0000, 16'(dg));
    wr(5'h14, 16'h0820);
    sreset();
    fails(1);
    chk("min_field", 16'h0000, 16'(dg));
    fails(1);
    chk("min_down", 16'h0001, 16'(dg));
    strap <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk("strap0", 16'h0000, 16'(ckin));
    chk("rmii_rst", 16'h0000, 16'(rp));
    end_sim;
  end
endmodule
`default_nettype wire
